// ---- hdl/rif_pkg.sv ----
// constants and types shared by the remote-input function logic
// ----------------------------------------------------------------
// Notes on behaviour
// - input counts only when pulled low for at least 20 ms.
// - inputs acting together: first input's function runs before the second's.
// - code 0: falling edge tares the scaled input.
// - code 1: falling edge clears total; totalizing continues regardless of level.
// - code 2: falling edge clears total; totalize only while low.
// - code 3: low level enables totalizing; high halts and keeps total.
// - code 4: low freezes display and stores total; processing continues live.
// - code 5: falling edge clears peak and valley buffers.
// - code 6: clear peak, show and track peak while low.
// - code 7: clear valley, show and track valley while low.
// - code 8 with alarm option: falling edge releases latched alarms.
// - code 9 with alarm option: low forces all alarms inactive.
// - code 10: falling edge toggles input/total view; rising edge nothing.
// - code 11: falling edge adds display to total then tares; batch bypass.
// - code 12: capture and hold display, then tare; release on rising edge.
// - code 13: low suspends operation; rising edge restarts conversion.
// - code 14: activation prints; low beyond 800 ms prints again.
// - second input only with totalizer option; same function set.
// - panel peak/valley reset allowed only when peak/valley display enabled.
// - display switching disallowed blocks the panel toggle; remote code 10 still toggles the view.
// - panel total reset and tare ignore the lockout pin.
// - tare buffer cleared by scaling step-through or serial command.
// ----------------------------------------------------------------
package rif_pkg;
    localparam longint unsigned CLK_HZ          = 64'd200_000_000;
    localparam longint unsigned MIN_LOW_MS      = 64'd20;
    localparam longint unsigned PRINT_REPEAT_MS = 64'd800;
    // least times round up
    localparam int unsigned MIN_LOW_CYC      = int'((MIN_LOW_MS * CLK_HZ + 64'd999) / 64'd1000);
    localparam int unsigned PRINT_REPEAT_CYC = int'((PRINT_REPEAT_MS * CLK_HZ + 64'd999) / 64'd1000);
    localparam int unsigned CNT_W            = 32;

    localparam logic [3:0] FN_TARE       = 4'h0;
    localparam logic [3:0] FN_TOT_RESET  = 4'h1;
    localparam logic [3:0] FN_TOT_GATE_R = 4'h2;
    localparam logic [3:0] FN_TOT_GATE   = 4'h3;
    localparam logic [3:0] FN_HOLD       = 4'h4;
    localparam logic [3:0] FN_PV_RESET   = 4'h5;
    localparam logic [3:0] FN_PEAK       = 4'h6;
    localparam logic [3:0] FN_VALLEY     = 4'h7;
    localparam logic [3:0] FN_ALM_RESET  = 4'h8;
    localparam logic [3:0] FN_ALM_OVRD   = 4'h9;
    localparam logic [3:0] FN_TOGGLE     = 4'hA;
    localparam logic [3:0] FN_BATCH      = 4'hB;
    localparam logic [3:0] FN_HOLD_TARE  = 4'hC;
    localparam logic [3:0] FN_SYNC       = 4'hD;
    localparam logic [3:0] FN_PRINT      = 4'hE;

    localparam logic SHOW_TOTAL_RST = 1'b0;
    localparam logic TOT_RUN_RST    = 1'b1;

    typedef struct packed {
        logic tare;
        logic tot_clr;
        logic snap;
        logic pk_clr;
        logic vl_clr;
        logic al_clr;
        logic toggle;
        logic batch;
        logic cap;
        logic cap_rel;
        logic restart;
        logic print;
    } rif_act_type;
endpackage

// ---- hdl/rif_qual_if.sv ----
// qualified remote-input events passed from the qualifier to the function logic
`timescale 1ns/1ps
`default_nettype none
interface rif_qual_if;
    logic active;
    logic fall;
    logic rise;
    modport src (output active, output fall, output rise);
    modport dst (input active, input fall, input rise);
endinterface
`default_nettype wire

// ---- hdl/rif_qual.sv ----
// synchroniser and low-time qualifier for one remote input
`timescale 1ns/1ps
`default_nettype none
module rif_qual #(
    parameter int unsigned LOW_CYCLES = rif_pkg::MIN_LOW_CYC
) (
    input  wire logic  ref_clk_in,
    input  wire logic  rst_n_in,
    input  wire logic  pin_n_in,
    input  wire logic  enable_in,
    rif_qual_if.src    q_out
);
    logic                     sync1_reg;
    logic                     sync2_reg;
    logic [rif_pkg::CNT_W-1:0] cnt_reg;
    logic                     active_reg;
    logic                     fall_reg;
    logic                     rise_reg;
    logic                     low_now;

    // ----------------------------------------------------------------
    // synchroniser
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync1_reg <= 1'b1;
            sync2_reg <= 1'b1;
        end else begin
            sync1_reg <= pin_n_in;
            sync2_reg <= sync1_reg;
        end
    end

    assign low_now = ~sync2_reg & enable_in;

    // ----------------------------------------------------------------
    // low-time qualification
    // ----------------------------------------------------------------
    // release is taken at once: a bounce on release is a fresh low that must count up again from zero
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_reg    <= '0;
            active_reg <= 1'b0;
            fall_reg   <= 1'b0;
            rise_reg   <= 1'b0;
        end else begin
            fall_reg <= 1'b0;
            rise_reg <= 1'b0;
            if (low_now) begin
                if (!active_reg) begin
                    if (cnt_reg >= rif_pkg::CNT_W'(LOW_CYCLES - 1)) begin
                        active_reg <= 1'b1;
                        fall_reg   <= 1'b1;
                    end else begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
            end else begin
                cnt_reg <= '0;
                if (active_reg) begin
                    active_reg <= 1'b0;
                    rise_reg   <= 1'b1;
                end
            end
        end
    end

    assign q_out.active = active_reg;
    assign q_out.fall   = fall_reg;
    assign q_out.rise   = rise_reg;
endmodule
`default_nettype wire

// ---- hdl/rif_top.sv ----
// remote-input function logic: qualifies two inputs and drives meter actions
`timescale 1ns/1ps
`default_nettype none
module rif_top #(
    parameter int unsigned MIN_LOW_CYCLES      = rif_pkg::MIN_LOW_CYC,
    parameter int unsigned PRINT_REPEAT_CYCLES = rif_pkg::PRINT_REPEAT_CYC
) (
    input  wire logic       ref_clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       remote_input_one_n_in,
    input  wire logic       remote_input_two_n_in,
    input  wire logic [3:0] fn_one_in,
    input  wire logic [3:0] fn_two_in,
    input  wire logic       totalizer_option_in,
    input  wire logic       alarm_option_in,
    input  wire logic       program_lockout_pin_n_in,
    input  wire logic       pv_display_en_in,
    input  wire logic       pv_reset_allow_in,
    input  wire logic       display_select_allow_in,
    input  wire logic       total_reset_allow_in,
    input  wire logic       tare_allow_in,
    input  wire logic       panel_pv_reset_in,
    input  wire logic       panel_toggle_in,
    input  wire logic       panel_total_reset_in,
    input  wire logic       panel_tare_in,
    input  wire logic       scaling_step_in,
    input  wire logic       serial_tare_clear_in,
    output logic            tare_out,
    output logic            tare_clear_out,
    output logic            total_clear_out,
    output logic            total_run_out,
    output logic            total_snapshot_out,
    output logic            display_hold_out,
    output logic            peak_clear_out,
    output logic            valley_clear_out,
    output logic            peak_track_out,
    output logic            valley_track_out,
    output logic            show_peak_out,
    output logic            show_valley_out,
    output logic            alarm_latch_clear_out,
    output logic            alarm_override_out,
    output logic            show_total_out,
    output logic            batch_add_out,
    output logic            batch_mode_out,
    output logic            capture_hold_out,
    output logic            conversion_suspend_out,
    output logic            conversion_restart_out,
    output logic            print_request_out,
    output logic            pv_reset_allow_out,
    output logic            lockout_active_out
);
    // ----------------------------------------------------------------
    // function decode
    // ----------------------------------------------------------------
    function automatic rif_pkg::rif_act_type decode_act(
        input logic [3:0] fn,
        input logic       fall,
        input logic       rise,
        input logic       alarm_opt
    );
        rif_pkg::rif_act_type a;
        a = '0;
        case (fn)
            rif_pkg::FN_TARE:       a.tare    = fall;
            rif_pkg::FN_TOT_RESET:  a.tot_clr = fall;
            rif_pkg::FN_TOT_GATE_R: a.tot_clr = fall;
            rif_pkg::FN_HOLD:       a.snap    = fall;
            rif_pkg::FN_PV_RESET: begin
                a.pk_clr = fall;
                a.vl_clr = fall;
            end
            rif_pkg::FN_PEAK:       a.pk_clr  = fall;
            rif_pkg::FN_VALLEY:     a.vl_clr  = fall;
            rif_pkg::FN_ALM_RESET:  a.al_clr  = fall & alarm_opt;
            rif_pkg::FN_TOGGLE:     a.toggle  = fall;
            rif_pkg::FN_BATCH:      a.batch   = fall;
            rif_pkg::FN_HOLD_TARE: begin
                a.cap     = fall;
                a.cap_rel = rise;
            end
            rif_pkg::FN_SYNC:       a.restart = rise;
            rif_pkg::FN_PRINT:      a.print   = fall;
            default:                a = '0;
        endcase
        return a;
    endfunction

    // ----------------------------------------------------------------
    // input qualification and per-input actions
    // ----------------------------------------------------------------
    rif_qual_if q_if[2] ();

    logic [3:0]          fn_sel [2];
    logic                lvl    [2];
    rif_pkg::rif_act_type ev    [2];

    assign fn_sel[0] = fn_one_in;
    assign fn_sel[1] = fn_two_in;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_in
            logic [rif_pkg::CNT_W-1:0] prt_cnt_reg;
            logic                      prt_again_reg;
            rif_pkg::rif_act_type      dec;

            rif_qual #(
                .LOW_CYCLES (MIN_LOW_CYCLES)
            ) u_qual (
                .ref_clk_in (ref_clk_in),
                .rst_n_in   (rst_n_in),
                .pin_n_in   ((gi == 0) ? remote_input_one_n_in : remote_input_two_n_in),
                .enable_in  ((gi == 0) ? 1'b1 : totalizer_option_in),
                .q_out      (q_if[gi])
            );

            // a long low time repeats the print once
            always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    prt_cnt_reg   <= '0;
                    prt_again_reg <= 1'b0;
                end else begin
                    prt_again_reg <= 1'b0;
                    if (q_if[gi].active && fn_sel[gi] == rif_pkg::FN_PRINT) begin
                        if (prt_cnt_reg == rif_pkg::CNT_W'(PRINT_REPEAT_CYCLES - 1)) begin
                            prt_again_reg <= 1'b1;
                        end
                        if (prt_cnt_reg < rif_pkg::CNT_W'(PRINT_REPEAT_CYCLES)) begin
                            prt_cnt_reg <= prt_cnt_reg + 1'b1;
                        end
                    end else begin
                        prt_cnt_reg <= '0;
                    end
                end
            end

            always_comb begin
                dec       = decode_act(fn_sel[gi], q_if[gi].fall, q_if[gi].rise, alarm_option_in);
                dec.print = dec.print | prt_again_reg;
                ev[gi]    = dec;
                lvl[gi]   = q_if[gi].active;
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // ordering of simultaneous events
    // ----------------------------------------------------------------
    // the second input is deferred one cycle when both act together
    rif_pkg::rif_act_type pend_reg;
    rif_pkg::rif_act_type pend_next;
    rif_pkg::rif_act_type act;

    always_comb begin
        pend_next = ((ev[0] != '0) && (ev[1] != '0)) ? ev[1] : '0;
        act       = ev[0] | pend_reg | ((ev[0] == '0) ? ev[1] : '0);
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pend_reg <= '0;
        end else begin
            pend_reg <= pend_next;
        end
    end

    // ----------------------------------------------------------------
    // level functions
    // ----------------------------------------------------------------
    function automatic logic lvl_fn(input logic [3:0] code, input int idx);
        return (fn_sel[idx] == code) && lvl[idx];
    endfunction

    function automatic logic sel_fn(input logic [3:0] code, input int idx);
        return fn_sel[idx] == code;
    endfunction

    logic any_gate;
    logic gate_ok;
    logic suspend;
    logic hold;
    logic pk_show;
    logic vl_show;
    logic pk_stop;
    logic vl_stop;
    logic ovrd;
    logic batch_sel;

    always_comb begin
        any_gate = 1'b0;
        gate_ok  = 1'b1;
        for (int i = 0; i < 2; i++) begin
            if (sel_fn(rif_pkg::FN_TOT_GATE_R, i) || sel_fn(rif_pkg::FN_TOT_GATE, i)) begin
                any_gate = 1'b1;
                gate_ok  = gate_ok & lvl[i];
            end
        end
        suspend   = lvl_fn(rif_pkg::FN_SYNC, 0) | lvl_fn(rif_pkg::FN_SYNC, 1);
        hold      = lvl_fn(rif_pkg::FN_HOLD, 0) | lvl_fn(rif_pkg::FN_HOLD, 1);
        pk_show   = lvl_fn(rif_pkg::FN_PEAK, 0) | lvl_fn(rif_pkg::FN_PEAK, 1);
        vl_show   = lvl_fn(rif_pkg::FN_VALLEY, 0) | lvl_fn(rif_pkg::FN_VALLEY, 1);
        pk_stop   = (sel_fn(rif_pkg::FN_PEAK, 0) | sel_fn(rif_pkg::FN_PEAK, 1)) & ~pk_show;
        vl_stop   = (sel_fn(rif_pkg::FN_VALLEY, 0) | sel_fn(rif_pkg::FN_VALLEY, 1)) & ~vl_show;
        ovrd      = (lvl_fn(rif_pkg::FN_ALM_OVRD, 0) | lvl_fn(rif_pkg::FN_ALM_OVRD, 1))
                    & alarm_option_in;
        batch_sel = sel_fn(rif_pkg::FN_BATCH, 0) | sel_fn(rif_pkg::FN_BATCH, 1);
    end

    // ----------------------------------------------------------------
    // level outputs
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            total_run_out          <= rif_pkg::TOT_RUN_RST;
            display_hold_out       <= 1'b0;
            peak_track_out         <= 1'b1;
            valley_track_out       <= 1'b1;
            show_peak_out          <= 1'b0;
            show_valley_out        <= 1'b0;
            alarm_override_out     <= 1'b0;
            batch_mode_out         <= 1'b0;
            conversion_suspend_out <= 1'b0;
            pv_reset_allow_out     <= 1'b0;
        end else begin
            // code 1 never gates, so the total keeps running after its clear
            total_run_out          <= (~any_gate | gate_ok) & ~suspend;
            display_hold_out       <= hold;
            peak_track_out         <= ~pk_stop;
            valley_track_out       <= ~vl_stop;
            show_peak_out          <= pk_show;
            show_valley_out        <= vl_show;
            alarm_override_out     <= ovrd;
            batch_mode_out         <= batch_sel;
            conversion_suspend_out <= suspend;
            pv_reset_allow_out     <= pv_display_en_in & pv_reset_allow_in;
        end
    end

    // ----------------------------------------------------------------
    // event outputs
    // ----------------------------------------------------------------
    logic tare_late_reg;
    logic lock_s1_reg;
    logic lock_s2_reg;

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tare_out               <= 1'b0;
            tare_late_reg          <= 1'b0;
            tare_clear_out         <= 1'b0;
            total_clear_out        <= 1'b0;
            total_snapshot_out     <= 1'b0;
            peak_clear_out         <= 1'b0;
            valley_clear_out       <= 1'b0;
            alarm_latch_clear_out  <= 1'b0;
            batch_add_out          <= 1'b0;
            conversion_restart_out <= 1'b0;
            print_request_out      <= 1'b0;
        end else begin
            // batch add and capture both come before their tare
            tare_late_reg          <= act.batch | act.cap;
            tare_out               <= act.tare | tare_late_reg | (panel_tare_in & tare_allow_in);
            tare_clear_out         <= scaling_step_in | serial_tare_clear_in;
            total_clear_out        <= act.tot_clr | (panel_total_reset_in & total_reset_allow_in);
            total_snapshot_out     <= act.snap;
            peak_clear_out         <= act.pk_clr | (panel_pv_reset_in & pv_display_en_in & pv_reset_allow_in);
            valley_clear_out       <= act.vl_clr | (panel_pv_reset_in & pv_display_en_in & pv_reset_allow_in);
            alarm_latch_clear_out  <= act.al_clr;
            batch_add_out          <= act.batch;
            conversion_restart_out <= act.restart;
            print_request_out      <= act.print;
        end
    end

    // ----------------------------------------------------------------
    // view and capture state
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            show_total_out <= rif_pkg::SHOW_TOTAL_RST;
        end else if (act.toggle || (panel_toggle_in && display_select_allow_in)) begin
            show_total_out <= ~show_total_out;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            capture_hold_out <= 1'b0;
        end else if (act.cap) begin
            capture_hold_out <= 1'b1;
        end else if (act.cap_rel) begin
            capture_hold_out <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // lockout pin status
    // ----------------------------------------------------------------
    // only reported: panel total reset and tare do not look at it
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lock_s1_reg        <= 1'b1;
            lock_s2_reg        <= 1'b1;
            lockout_active_out <= 1'b0;
        end else begin
            lock_s1_reg        <= program_lockout_pin_n_in;
            lock_s2_reg        <= lock_s1_reg;
            lockout_active_out <= ~lock_s2_reg;
        end
    end
endmodule
`default_nettype wire

// ---- tb/rif_contact.sv ----
// contact model that closes a remote input to signal common
`timescale 1ns/1ps
`default_nettype none
module rif_contact (
    input  wire logic closed_in,
    output logic      pin_n_out
);
    // an open contact leaves the pull-up in charge, so the pin reads high
    assign pin_n_out = closed_in ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// ---- tb/rif_top_assertions.sv ----
// concurrent checks on the remote-input function ports
`timescale 1ns/1ps
`default_nettype none
module rif_top_assertions (
    input wire logic       ref_clk_in, rst_n_in, remote_input_one_n_in, remote_input_two_n_in,
    input wire logic [3:0] fn_one_in, fn_two_in,
    input wire logic       alarm_option_in, pv_display_en_in, total_reset_allow_in, tare_allow_in,
    input wire logic       panel_total_reset_in, panel_tare_in, scaling_step_in, serial_tare_clear_in,
    input wire logic       tare_out, tare_clear_out, total_clear_out, alarm_latch_clear_out,
    input wire logic       alarm_override_out, batch_add_out, conversion_suspend_out,
    input wire logic       conversion_restart_out, print_request_out, pv_reset_allow_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_quiet;
        remote_input_one_n_in && remote_input_two_n_in && !panel_tare_in;
    endsequence
    sequence s_no_alarm;
        !alarm_option_in [*3];
    endsequence
    // eight idle cycles leave no qualified edge in the pipeline
    a_no_idle_tare: assert property (s_quiet [*8] |-> !tare_out) else $error("tare while idle");
    a_batch_then_tare: assert property (batch_add_out |=> tare_out) else $error("batch without tare");
    a_restart_cause: assert property (conversion_restart_out |-> $past(conversion_suspend_out)
        && (fn_one_in == 4'hD || fn_two_in == 4'hD)) else $error("restart without suspend");
    a_print_pulse: assert property (print_request_out |-> (fn_one_in == 4'hE || fn_two_in == 4'hE)
        ##1 !print_request_out) else $error("print pulse wrong");
    a_alarm_gate: assert property (s_no_alarm |-> !alarm_override_out && !alarm_latch_clear_out)
        else $error("alarm action without option");
    a_panel_tare: assert property (panel_tare_in && tare_allow_in |=> tare_out)
        else $error("panel tare lost");
    a_panel_total: assert property (panel_total_reset_in && total_reset_allow_in |=> total_clear_out)
        else $error("panel total reset lost");
    a_pv_allow_gate: assert property (!pv_display_en_in |=> !pv_reset_allow_out)
        else $error("pv reset allowed without pv display");
    a_tare_clr_cause: assert property (scaling_step_in || serial_tare_clear_in |=> tare_clear_out)
        else $error("tare buffer not cleared");
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// self-checking bench for the remote-input function logic
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int M = 8;
    localparam int P = 20;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [1:0]  closed = 2'h0;
    wire  [1:0]  pin_n;
    logic [3:0]  fn1 = 4'hF;
    logic [3:0]  fn2 = 4'hF;
    logic [7:0]  cfg = 8'hFF;
    logic [5:0]  pn = 6'h00;
    wire  [22:0] o;
    logic [22:0] hit;
    int          rc [23];
    int          first [23];
    int          errors = 0;
    int          samples_checked = 0;
    rif_contact c1 (.closed_in(closed[0]), .pin_n_out(pin_n[0]));
    rif_contact c2 (.closed_in(closed[1]), .pin_n_out(pin_n[1]));
    rif_top #(.MIN_LOW_CYCLES(M), .PRINT_REPEAT_CYCLES(P)) dut (
        .ref_clk_in(clk), .rst_n_in(rst_n), .remote_input_one_n_in(pin_n[0]),
        .remote_input_two_n_in(pin_n[1]), .fn_one_in(fn1), .fn_two_in(fn2), .totalizer_option_in(cfg[0]),
        .alarm_option_in(cfg[1]), .program_lockout_pin_n_in(cfg[2]), .pv_display_en_in(cfg[3]),
        .pv_reset_allow_in(cfg[4]), .display_select_allow_in(cfg[5]), .total_reset_allow_in(cfg[6]),
        .tare_allow_in(cfg[7]), .panel_pv_reset_in(pn[0]), .panel_toggle_in(pn[1]),
        .panel_total_reset_in(pn[2]), .panel_tare_in(pn[3]), .scaling_step_in(pn[4]),
        .serial_tare_clear_in(pn[5]), .tare_out(o[0]), .tare_clear_out(o[1]), .total_clear_out(o[2]),
        .total_run_out(o[3]), .total_snapshot_out(o[4]), .display_hold_out(o[5]), .peak_clear_out(o[6]),
        .valley_clear_out(o[7]), .peak_track_out(o[8]), .valley_track_out(o[9]), .show_peak_out(o[10]),
        .show_valley_out(o[11]), .alarm_latch_clear_out(o[12]), .alarm_override_out(o[13]),
        .show_total_out(o[14]), .batch_add_out(o[15]), .batch_mode_out(o[16]), .capture_hold_out(o[17]),
        .conversion_suspend_out(o[18]), .conversion_restart_out(o[19]), .print_request_out(o[20]),
        .pv_reset_allow_out(o[21]), .lockout_active_out(o[22]));
    initial forever #2.5 clk = ~clk;
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %0d seen %0d", nm, exp, got);
        end
    endtask
    // closes contacts ch for n cycles, pulses panel inputs pm, records rises over a bounded window
    task automatic run(input logic [1:0] ch, input int n, input logic [5:0] pm);
        logic [22:0] prev;
        prev = o;
        hit = '0;
        for (int i = 0; i < 23; i++) begin
            rc[i] = 0;
            first[i] = -1;
        end
        for (int t = 0; t < n + 8; t++) begin
            @(posedge clk);
            closed <= (t < n) ? ch : 2'h0;
            pn <= (t == 0) ? pm : 6'h00;
            #1;
            hit = hit | o;
            for (int i = 0; i < 23; i++) begin
                if (o[i] && !prev[i]) begin
                    rc[i]++;
                    if (first[i] < 0) first[i] = t;
                end
            end
            prev = o;
        end
    endtask
    task automatic sc_codes();
        int tgt [15] = '{0, 2, 2, 3, 5, 6, 10, 11, 12, 13, 14, 15, 17, 18, 20};
        for (int c = 0; c < 15; c++) begin
            fn1 <= 4'(c);
            run(2'h0, 4, 6'h00);
            run(2'h1, M + 6, 6'h00);
            chk("function output", 1, hit[tgt[c]]);
            chk("total snapshot", c == 4, hit[4]);
            chk("batch mode", c == 11, hit[16]);
            chk("valley track", c != 7, o[9]);
            chk("run gate", c != 2 && c != 3, o[3]);
        end
    endtask
    task automatic sc_levels();
        fn1 <= 4'h2;
        run(2'h1, M + 6, 6'h00);
        chk("gated run released", 0, o[3]);
        fn1 <= 4'h1;
        run(2'h1, M + 6, 6'h00);
        chk("run after clear", 1, o[3]);
        fn1 <= 4'h6;
        run(2'h1, M + 6, 6'h00);
        chk("peak track released", 0, o[8]);
        fn1 <= 4'hA;
        run(2'h1, M + 6, 6'h00);
        chk("view after toggle", 0, o[14]);
        run(2'h1, M + 6, 6'h00);
        chk("view toggled back", 1, o[14]);
        fn1 <= 4'hE;
        run(2'h1, M + P + 8, 6'h00);
        chk("long low prints", 2, rc[20]);
        fn1 <= 4'hB;
        run(2'h1, M + 6, 6'h00);
        chk("tare after batch", first[15] + 1, first[0]);
        fn1 <= 4'hC;
        run(2'h1, M + 6, 6'h00);
        chk("tare after capture", first[17] + 1, first[0]);
        chk("capture released", 0, o[17]);
        fn1 <= 4'hD;
        fn2 <= 4'h0;
        run(2'h3, M + 6, 6'h00);
        chk("restart pulses", 1, rc[19]);
        chk("other input served", 1, hit[0]);
        fn1 <= 4'h5;
        run(2'h3, M + 6, 6'h00);
        chk("second input follows", first[6] + 1, first[0]);
    endtask
    task automatic sc_refuse();
        fn1 <= 4'h0;
        run(2'h1, M - 3, 6'h00);
        chk("short low tare", 0, hit[0]);
        cfg[1] <= 1'b0;
        fn1 <= 4'h9;
        run(2'h1, M + 6, 6'h00);
        chk("override no option", 0, hit[13]);
        fn1 <= 4'h8;
        run(2'h1, M + 6, 6'h00);
        chk("latch clear no option", 0, hit[12]);
        fn1 <= 4'hF;
        cfg[0] <= 1'b0;
        run(2'h2, M + 6, 6'h00);
        chk("input two no option", 0, hit[0]);
        cfg[0] <= 1'b1;
        fn2 <= 4'h5;
        run(2'h2, M + 6, 6'h00);
        chk("input two valley clear", 1, hit[7]);
    endtask
    task automatic sc_panel();
        cfg[5] <= 1'b0;
        run(2'h0, 2, 6'h02);
        chk("view locked", 1, o[14]);
        cfg[2] <= 1'b0;
        run(2'h0, 2, 6'h04);
        chk("panel total reset", 1, rc[2]);
        chk("lockout seen", 1, o[22]);
        run(2'h0, 2, 6'h08);
        chk("panel tare", 1, rc[0]);
        cfg[3] <= 1'b0;
        run(2'h0, 2, 6'h10);
        chk("pv reset forced off", 0, o[21]);
        chk("step clears tare", 1, rc[1]);
        cfg[3] <= 1'b1;
        run(2'h0, 2, 6'h20);
        chk("pv reset allowed", 1, o[21]);
        chk("serial clears tare", 1, rc[1]);
    endtask
    task automatic finish_test();
        if (errors == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // watchdog: a hung run still reaches the verdict
    initial begin
        #300000;
        errors++;
        finish_test();
    end
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        sc_codes();
        sc_levels();
        sc_refuse();
        sc_panel();
        finish_test();
    end
endmodule
bind rif_top rif_top_assertions chk_u (.*);
`default_nettype wire
